/* File: bench/sxc_top_tb_top.sv */
// sxc_top_tb_top: self-checking bench of the housekeeping block
// assumes: sxc_pkg and sxc_map.svh compiled first; bench drives every port itself
`timescale 1ns/1ps
`include "sxc_map.svh"
module sxc_top_tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        mclk, reset_n, ret_reset_n, acc_wr, acc_rd;
  logic [3:0]  acc_sel;
  logic [31:0] acc_wdata, acc_rdata_ff, rd_v;
  logic [7:0]  cpu_irq, periph_status;
  logic        periph_req, force_fast_ff, restore_cfg_ff, sram_write, sram_fetch;
  logic [15:0] sram_addr;
  logic        sram_wr_deny_ff, sram_ex_deny_ff, slow_osc_good, clk_req_err, flash_wait_ff;
  logic [1:0]  mclk_src, fast_osc_freq;
  logic        sleep_req, wake_event, core_reg_off_ff, brownout_reset_ff, io_hold_ff, swd_lock_ff;
  logic [31:0] io_cfg_live, io_cfg_held_ff;
  int          failures, tests_run, cyc, n;
  logic        seen_rst;
  localparam logic [31:0] KEY = {`SXC_KEY_VAL, 24'h000000};

  sxc_top dut (.mclk(mclk), .reset_n(reset_n), .ret_reset_n(ret_reset_n), .acc_wr(acc_wr),
    .acc_rd(acc_rd), .acc_sel(acc_sel), .acc_wdata(acc_wdata), .acc_rdata_ff(acc_rdata_ff),
    .cpu_irq(cpu_irq), .periph_req(periph_req), .force_fast_ff(force_fast_ff),
    .restore_cfg_ff(restore_cfg_ff), .sram_addr(sram_addr), .sram_write(sram_write),
    .sram_fetch(sram_fetch), .sram_wr_deny_ff(sram_wr_deny_ff), .sram_ex_deny_ff(sram_ex_deny_ff),
    .mclk_src(mclk_src), .fast_osc_freq(fast_osc_freq), .slow_osc_good(slow_osc_good),
    .clk_req_err(clk_req_err), .flash_wait_ff(flash_wait_ff), .periph_status(periph_status),
    .sleep_req(sleep_req), .wake_event(wake_event), .io_cfg_live(io_cfg_live),
    .core_reg_off_ff(core_reg_off_ff), .brownout_reset_ff(brownout_reset_ff),
    .io_hold_ff(io_hold_ff), .io_cfg_held_ff(io_cfg_held_ff), .swd_lock_ff(swd_lock_ff));

  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // whole run is well under 2000 cycles; 5000 leaves margin for slow answers
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (restore_cfg_ff === 1'b1) seen_rst <= 1'b1;
    if (cyc == 5000) begin
      failures = failures + 1;
      $display("[ERR] timeout expected finish seen hang");
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    @(posedge mclk);
    acc_wr <= 1'b1; acc_sel <= s; acc_wdata <= d;
    @(posedge mclk);
    acc_wr <= 1'b0;
  endtask

  // read data lands on the edge that samples acc_rd, so look at the next falling edge
  task automatic rd(input logic [3:0] s);
    @(posedge mclk);
    acc_rd <= 1'b1; acc_sel <= s;
    @(posedge mclk);
    acc_rd <= 1'b0;
    @(negedge mclk);
    rd_v = acc_rdata_ff;
  endtask

  task automatic cyc_n(input int k);
    repeat (k) @(posedge mclk);
    @(negedge mclk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_sram();
    logic [15:0] a;
    wr(`SXC_SEL_BOUNDARY, 32'h00000040);
    for (int i = 0; i < 2; i++) begin
      a = 16'h003f + 16'(i);
      @(posedge mclk);
      sram_addr <= a; sram_write <= 1'b1; sram_fetch <= 1'b1;
      cyc_n(1);
      chk("wr_deny", 32'(i), 32'(sram_wr_deny_ff));
      chk("ex_deny", 32'(1 - i), 32'(sram_ex_deny_ff));
    end
    @(posedge mclk);
    sram_write <= 1'b0; sram_fetch <= 1'b0;
    $display("test sram boundary done");
  endtask

  task automatic t_lock();
    wr(`SXC_SEL_LOCK, 32'h00000001);
    wr(`SXC_SEL_BOUNDARY, 32'h00000080);
    rd(`SXC_SEL_BOUNDARY); chk("boundary locked", 32'h40, 32'(rd_v[15:0]));
    wr(`SXC_SEL_OSCCFG, KEY | 32'h1);
    rd(`SXC_SEL_OSCCFG); chk("osccfg locked", 32'h0, 32'(rd_v[1:0]));
    wr(`SXC_SEL_STORE, 32'h5a3c0f96);
    rd(`SXC_SEL_STORE); chk("store exempt", 32'h5a3c0f96, rd_v);
    wr(`SXC_SEL_LOCK, 32'h00000000);
    rd(`SXC_SEL_LOCK); chk("lock exempt", 32'h0, 32'(rd_v[0]));
    wr(`SXC_SEL_OSCCFG, 32'h5a000001);
    rd(`SXC_SEL_OSCCFG); chk("osccfg bad key", 32'h0, 32'(rd_v[1:0]));
    $display("test write lock done");
  endtask

  task automatic t_fast();
    wr(`SXC_SEL_OSCCFG, KEY | 32'h1);
    @(posedge mclk); cpu_irq <= 8'h04;
    cyc_n(2); chk("force on irq", 32'h1, 32'(force_fast_ff));
    seen_rst <= 1'b0;
    @(posedge mclk); cpu_irq <= 8'h00;
    n = 0;
    while (force_fast_ff === 1'b1 && n < 80) begin
      @(negedge mclk); n++;
    end
    chk("hold long enough", 32'h1, 32'(n >= 41 && n <= 45));
    cyc_n(2); chk("restore pulse", 32'h1, 32'(seen_rst));
    // a config write during the request must suppress the restore pulse
    seen_rst <= 1'b0;
    @(posedge mclk); cpu_irq <= 8'h04;
    wr(`SXC_SEL_OSCCFG, KEY | 32'h1);
    @(posedge mclk); cpu_irq <= 8'h00;
    cyc_n(50); chk("no restore after write", 32'h0, 32'(seen_rst));
    wr(`SXC_SEL_OSCCFG, KEY | 32'h3);
    @(posedge mclk); periph_req <= 1'b1; cpu_irq <= 8'h80;
    cyc_n(5); chk("blocked", 32'h0, 32'(force_fast_ff));
    @(posedge mclk); periph_req <= 1'b0;
    wr(`SXC_SEL_OSCCFG, KEY);
    cyc_n(3); chk("irq not enabled", 32'h0, 32'(force_fast_ff));
    @(posedge mclk); periph_req <= 1'b0; cpu_irq <= 8'h00;
    $display("test fast request done");
  endtask

  task automatic t_shdn();
    wr(`SXC_SEL_PMODE, KEY | 32'(`SXC_PMODE_SHDN));
    @(posedge mclk); sleep_req <= 1'b1; io_cfg_live <= 32'hc0fe0123;
    @(posedge mclk); sleep_req <= 1'b0;
    @(negedge mclk);
    chk("regulator off", 32'h1, 32'(core_reg_off_ff));
    chk("hold and debug lock", 32'h3, 32'({io_hold_ff, swd_lock_ff}));
    @(posedge mclk); io_cfg_live <= 32'h00000000;
    cyc_n(3); chk("held cfg", 32'hc0fe0123, io_cfg_held_ff);
    @(posedge mclk); wake_event <= 1'b1;
    n = 0;
    while (brownout_reset_ff !== 1'b1 && n < 10) begin
      @(negedge mclk); n++;
    end
    chk("brownout on exit", 32'h1, 32'(brownout_reset_ff));
    @(posedge mclk); wake_event <= 1'b0; reset_n <= 1'b0;
    cyc_n(2);
    chk("off cleared", 32'h0, 32'(core_reg_off_ff));
    chk("still held", 32'h3, 32'({io_hold_ff, swd_lock_ff}));
    @(posedge mclk); reset_n <= 1'b1;
    rd(`SXC_SEL_STORE); chk("store kept", 32'h5a3c0f96, rd_v);
    rd(`SXC_SEL_CAUSE); chk("cause set", 32'h1, 32'(rd_v[0]));
    rd(`SXC_SEL_CAUSE); chk("cause cleared", 32'h0, 32'(rd_v[0]));
    wr(`SXC_SEL_IOREL, 32'h00000001);
    rd(`SXC_SEL_IOREL); chk("no key no release", 32'h1, 32'(rd_v[0]));
    @(posedge mclk); io_cfg_live <= 32'h0000beef;
    wr(`SXC_SEL_IOREL, KEY | 32'h1);
    cyc_n(1); chk("released", 32'h0, 32'({io_hold_ff, swd_lock_ff}));
    $display("test shutdown done");
  endtask

  task automatic t_status();
    // software choice of 0 first, so the automatic fast choice is visible
    wr(`SXC_SEL_FLASHWS, 32'h00000000);
    cyc_n(2); chk("wait software", 32'h0, 32'(flash_wait_ff));
    @(posedge mclk);
    mclk_src <= 2'b00; fast_osc_freq <= 2'b10; slow_osc_good <= 1'b1;
    clk_req_err <= 1'b1; periph_status <= 8'ha6;
    cyc_n(3); chk("wait fast", 32'(`SXC_WS_FAST), 32'(flash_wait_ff));
    rd(`SXC_SEL_CLKSTAT); chk("clock status", 32'h64, 32'(rd_v[6:0]));
    rd(`SXC_SEL_SYSSTAT); chk("system status", 32'ha6, 32'(rd_v[7:0]));
    @(posedge mclk); mclk_src <= 2'b01;
    cyc_n(3); chk("wait slow", 32'(`SXC_WS_SLOW), 32'(flash_wait_ff));
    $display("test status done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    failures = 0; tests_run = 0; cyc = 0; seen_rst = 1'b0;
    reset_n = 1'b0; ret_reset_n = 1'b0; acc_wr = 1'b0; acc_rd = 1'b0;
    acc_sel = 4'h0; acc_wdata = 32'h0; cpu_irq = 8'h00; periph_req = 1'b0;
    sram_addr = 16'h0; sram_write = 1'b0; sram_fetch = 1'b0; mclk_src = 2'b10;
    fast_osc_freq = 2'b00; slow_osc_good = 1'b0; clk_req_err = 1'b0; periph_status = 8'h00;
    sleep_req = 1'b0; wake_event = 1'b0; io_cfg_live = 32'h0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1; ret_reset_n <= 1'b1;
    t_sram();
    t_lock();
    t_fast();
    t_shdn();
    t_status();
    wrap_up();
  end
endmodule

/* File: inc/sxc_map.svh */
// sxc_map.svh: offsets, field positions, keys and counts of the system controller housekeeping block
// assumes: included by bare name from the bench and design files
`ifndef SXC_MAP_SVH
`define SXC_MAP_SVH

// ------------------------------------------------------------
// register select codes of the access port
// ------------------------------------------------------------
`define SXC_SEL_LOCK      4'h0
`define SXC_SEL_OSCCFG    4'h1
`define SXC_SEL_BOUNDARY  4'h2
`define SXC_SEL_PMODE     4'h3
`define SXC_SEL_IOREL     4'h4
`define SXC_SEL_CAUSE     4'h5
`define SXC_SEL_STORE     4'h6
`define SXC_SEL_CLKSTAT   4'h7
`define SXC_SEL_SYSSTAT   4'h8
`define SXC_SEL_FLASHWS   4'h9

// ------------------------------------------------------------
// field positions and key
// ------------------------------------------------------------
`define SXC_KEY_MSB       31
`define SXC_KEY_LSB       24
`define SXC_KEY_VAL       8'ha5
`define SXC_LOCK_BIT      0
`define SXC_FASTEN_BIT    0
`define SXC_BLOCK_BIT     1
`define SXC_REL_BIT       0
`define SXC_PMODE_SHDN    2'h3

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define SXC_BOUNDARY_RST  16'h0000
`define SXC_FAST_HOLD_CYC 41
`define SXC_WS_FAST       1'b1
`define SXC_WS_SLOW       1'b0

`endif

/* File: inc/sxc_pkg.sv */
// sxc_pkg: types shared by the system controller housekeeping modules
// assumes: compiled before all design files
package sxc_pkg;
  typedef enum logic [1:0] {
    SXC_SRC_FAST  = 2'b00,
    SXC_SRC_SLOW  = 2'b01,
    SXC_SRC_OTHER = 2'b10
  } sxc_mclk_src_t;

  typedef enum logic [1:0] {
    SXC_FR_IDLE = 2'b00,
    SXC_FR_REQ  = 2'b01,
    SXC_FR_HOLD = 2'b10
  } sxc_fr_state_t;
endpackage

/* File: logic/sxc_fast_req.sv */
// sxc_fast_req: asynchronous fast clock request gating and post-request hold
// assumes: request inputs synchronous to mclk; hold counted in mclk cycles
`timescale 1ns/1ps
`include "sxc_map.svh"
module sxc_fast_req #(
  parameter int IRQ_W    = 8,
  parameter int HOLD_CYC = `SXC_FAST_HOLD_CYC
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // requests and configuration
  input  wire logic [IRQ_W-1:0] cpu_irq,
  input  wire logic             periph_req,
  input  wire logic             irq_fast_en,
  input  wire logic             global_block,
  input  wire logic             cfg_changed,
  // results
  output logic                  force_fast,
  output logic                  restore_cfg
);
  localparam int CW = $clog2(HOLD_CYC + 1);
  sxc_pkg::sxc_fr_state_t state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          chg_ff, nxt_chg;
  logic          rst_ff, nxt_rst;
  logic          req;

  // ------------------------------------------------------------
  // request merge
  // ------------------------------------------------------------
  assign req = !global_block && (periph_req || (irq_fast_en && |cpu_irq));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_chg   = chg_ff | cfg_changed;
    nxt_rst   = 1'b0;
    case (state_ff)
      sxc_pkg::SXC_FR_IDLE: begin
        nxt_chg = 1'b0;
        if (req) begin
          nxt_state = sxc_pkg::SXC_FR_REQ;
        end
      end
      sxc_pkg::SXC_FR_REQ: begin
        if (!req) begin
          nxt_state = sxc_pkg::SXC_FR_HOLD;
          nxt_cnt   = CW'(HOLD_CYC - 1);
        end
      end
      sxc_pkg::SXC_FR_HOLD: begin
        if (req) begin
          nxt_state = sxc_pkg::SXC_FR_REQ;
        end else if (cnt_ff == '0) begin
          nxt_state = sxc_pkg::SXC_FR_IDLE;
          nxt_rst   = !nxt_chg;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: nxt_state = sxc_pkg::SXC_FR_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= sxc_pkg::SXC_FR_IDLE;
      cnt_ff   <= '0;
      chg_ff   <= 1'b0;
      rst_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      chg_ff   <= nxt_chg;
      rst_ff   <= nxt_rst;
    end
  end

  assign force_fast  = state_ff != sxc_pkg::SXC_FR_IDLE;
  assign restore_cfg = rst_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_req_drop;
    req ##1 !req;
  endsequence
  sequence s_held;
    force_fast [*8];
  endsequence
  property p_irq_forces;
    @(posedge mclk) disable iff (!reset_n)
      (irq_fast_en && !global_block && |cpu_irq) |=> force_fast;
  endproperty
  a_irq_forces: assert property (p_irq_forces) else $error("irq did not force fast clock");
  property p_block;
    @(posedge mclk) disable iff (!reset_n)
      (global_block && !force_fast) |=> !force_fast;
  endproperty
  a_block: assert property (p_block) else $error("blocked request took effect");
  property p_hold;
    @(posedge mclk) disable iff (!reset_n)
      s_req_drop |=> s_held;
  endproperty
  a_hold: assert property (p_hold) else $error("fast clock released early");
endmodule

/* File: logic/sxc_sram_guard.sv */
// sxc_sram_guard: write-exclusive-execute check against the sram boundary
// assumes: one access per cycle, word address relative to sram base
`timescale 1ns/1ps
module sxc_sram_guard #(
  parameter int AW = 16
) (
  // access
  input  wire logic [AW-1:0] addr,
  input  wire logic          is_write,
  input  wire logic          is_fetch,
  input  wire logic [AW-1:0] boundary,
  // verdict
  output logic               wr_deny,
  output logic               ex_deny
);
  logic upper;
  assign upper   = addr >= boundary;
  assign wr_deny = is_write && upper;
  assign ex_deny = is_fetch && !upper;
endmodule

/* File: logic/sxc_top.sv */
// sxc_top: system controller housekeeping: fast requests, sram guard, flash waits, shutdown, lock
// assumes: access port and status inputs synchronous to mclk; ret_reset_n only at power-on
`timescale 1ns/1ps
`include "sxc_map.svh"
// Function
// - cpu interrupt raises fast clock request when enabled
// - below boundary read-write, above read-execute
// - flash waits chosen automatically for fast/slow clocks
// - shutdown powers regulator off, exit gives brownout
// - pin states latched at shutdown entry, frozen
// - pins released only by keyed release write
// - debug pins locked until pin release
// - four retained bytes survive shutdown, readable
// - lock active blocks protected register writes
// - listed registers exempt from the write lock
// - reading reset cause clears it
// - keyed registers ignore writes with wrong key
// - clock status reports osc, source, slow osc, error
// - system status shows peripheral status bits
// - forced fast clock held 41 cycles after drop
// - global block ignores all fast requests
module sxc_top #(
  parameter int IRQ_W  = 8,
  parameter int AW     = 16,
  parameter int IO_W   = 32,
  parameter int STAT_W = 8
) (
  // clock and resets
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              ret_reset_n,
  // register access
  input  wire logic              acc_wr,
  input  wire logic              acc_rd,
  input  wire logic [3:0]        acc_sel,
  input  wire logic [31:0]       acc_wdata,
  output logic [31:0]            acc_rdata_ff,
  // fast clock requests
  input  wire logic [IRQ_W-1:0]  cpu_irq,
  input  wire logic              periph_req,
  output logic                   force_fast_ff,
  output logic                   restore_cfg_ff,
  // sram access check
  input  wire logic [AW-1:0]     sram_addr,
  input  wire logic              sram_write,
  input  wire logic              sram_fetch,
  output logic                   sram_wr_deny_ff,
  output logic                   sram_ex_deny_ff,
  // clock status
  input  wire logic [1:0]        mclk_src,
  input  wire logic [1:0]        fast_osc_freq,
  input  wire logic              slow_osc_good,
  input  wire logic              clk_req_err,
  output logic                   flash_wait_ff,
  // peripheral status
  input  wire logic [STAT_W-1:0] periph_status,
  // shutdown
  input  wire logic              sleep_req,
  input  wire logic              wake_event,
  input  wire logic [IO_W-1:0]   io_cfg_live,
  output logic                   core_reg_off_ff,
  output logic                   brownout_reset_ff,
  output logic                   io_hold_ff,
  output logic [IO_W-1:0]        io_cfg_held_ff,
  output logic                   swd_lock_ff
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic key_ok(input logic [31:0] d);
    key_ok = d[`SXC_KEY_MSB:`SXC_KEY_LSB] == `SXC_KEY_VAL;
  endfunction

  logic            wr_lock, wr_osc, wr_bnd, wr_pm, wr_rel, wr_sto, wr_ws, rd_cause;
  logic            lock_ff, nxt_lock;
  logic            fast_en_ff, nxt_fast_en;
  logic            block_ff, nxt_block;
  logic [AW-1:0]   bnd_ff, nxt_bnd;
  logic [1:0]      pmode_ff, nxt_pmode;
  logic            ws_sw_ff, nxt_ws_sw;
  logic            ff_fast, ff_rst, g_wr, g_ex;
  logic            nxt_flash_wait;
  logic [31:0]     nxt_rdata;
  logic            shdn_enter;
  logic            nxt_core_off, nxt_brownout_reset, nxt_hold;
  logic [IO_W-1:0] nxt_held;
  logic [31:0]     store_ff, nxt_store;
  logic            cause_ff, nxt_cause;

  // ------------------------------------------------------------
  // write qualification
  // ------------------------------------------------------------
  always_comb begin
    wr_lock  = acc_wr && acc_sel == `SXC_SEL_LOCK;
    wr_osc   = acc_wr && acc_sel == `SXC_SEL_OSCCFG && !lock_ff && key_ok(acc_wdata);
    wr_bnd   = acc_wr && acc_sel == `SXC_SEL_BOUNDARY && !lock_ff;
    wr_ws    = acc_wr && acc_sel == `SXC_SEL_FLASHWS && !lock_ff;
    wr_pm    = acc_wr && acc_sel == `SXC_SEL_PMODE && key_ok(acc_wdata);
    wr_rel   = acc_wr && acc_sel == `SXC_SEL_IOREL && key_ok(acc_wdata)
               && acc_wdata[`SXC_REL_BIT];
    wr_sto   = acc_wr && acc_sel == `SXC_SEL_STORE;
    rd_cause = acc_rd && acc_sel == `SXC_SEL_CAUSE;
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  // a refused write simply keeps the old value; no error path exists
  always_comb begin
    nxt_lock    = wr_lock ? acc_wdata[`SXC_LOCK_BIT] : lock_ff;
    nxt_fast_en = wr_osc ? acc_wdata[`SXC_FASTEN_BIT] : fast_en_ff;
    nxt_block   = wr_osc ? acc_wdata[`SXC_BLOCK_BIT] : block_ff;
    nxt_bnd     = wr_bnd ? acc_wdata[AW-1:0] : bnd_ff;
    nxt_ws_sw   = wr_ws ? acc_wdata[0] : ws_sw_ff;
    nxt_pmode   = wr_pm ? acc_wdata[1:0] : pmode_ff;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lock_ff    <= 1'b0;
      fast_en_ff <= 1'b0;
      block_ff   <= 1'b0;
      bnd_ff     <= `SXC_BOUNDARY_RST;
      ws_sw_ff   <= 1'b1;
      pmode_ff   <= 2'h0;
    end else begin
      lock_ff    <= nxt_lock;
      fast_en_ff <= nxt_fast_en;
      block_ff   <= nxt_block;
      bnd_ff     <= nxt_bnd;
      ws_sw_ff   <= nxt_ws_sw;
      pmode_ff   <= nxt_pmode;
    end
  end

  // ------------------------------------------------------------
  // fast requests and sram guard
  // ------------------------------------------------------------
  sxc_fast_req #(
    .IRQ_W    (IRQ_W),
    .HOLD_CYC (`SXC_FAST_HOLD_CYC)
  ) u_fast (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .cpu_irq      (cpu_irq),
    .periph_req   (periph_req),
    .irq_fast_en  (fast_en_ff),
    .global_block (block_ff),
    .cfg_changed  (wr_osc),
    .force_fast   (ff_fast),
    .restore_cfg  (ff_rst)
  );

  sxc_sram_guard #(
    .AW (AW)
  ) u_guard (
    .addr     (sram_addr),
    .is_write (sram_write),
    .is_fetch (sram_fetch),
    .boundary (bnd_ff),
    .wr_deny  (g_wr),
    .ex_deny  (g_ex)
  );

  // ------------------------------------------------------------
  // flash waits and read data
  // ------------------------------------------------------------
  always_comb begin
    if (mclk_src == sxc_pkg::SXC_SRC_FAST) begin
      nxt_flash_wait = `SXC_WS_FAST;
    end else if (mclk_src == sxc_pkg::SXC_SRC_SLOW) begin
      nxt_flash_wait = `SXC_WS_SLOW;
    end else begin
      nxt_flash_wait = ws_sw_ff;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (!acc_rd) begin
      nxt_rdata = 32'h0000_0000;
    end else if (acc_sel == `SXC_SEL_LOCK) begin
      nxt_rdata[0] = lock_ff;
    end else if (acc_sel == `SXC_SEL_OSCCFG) begin
      nxt_rdata[1:0] = {block_ff, fast_en_ff};
    end else if (acc_sel == `SXC_SEL_BOUNDARY) begin
      nxt_rdata[AW-1:0] = bnd_ff;
    end else if (acc_sel == `SXC_SEL_PMODE) begin
      nxt_rdata[1:0] = pmode_ff;
    end else if (acc_sel == `SXC_SEL_IOREL) begin
      nxt_rdata[0] = io_hold_ff;
    end else if (acc_sel == `SXC_SEL_CAUSE) begin
      nxt_rdata[0] = cause_ff;
    end else if (acc_sel == `SXC_SEL_STORE) begin
      nxt_rdata = store_ff;
    end else if (acc_sel == `SXC_SEL_CLKSTAT) begin
      nxt_rdata[6:0] = {clk_req_err, slow_osc_good, mclk_src, fast_osc_freq, ff_fast};
    end else if (acc_sel == `SXC_SEL_SYSSTAT) begin
      nxt_rdata[STAT_W-1:0] = periph_status;
    end else if (acc_sel == `SXC_SEL_FLASHWS) begin
      nxt_rdata[0] = ws_sw_ff;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      acc_rdata_ff    <= 32'h0000_0000;
      force_fast_ff   <= 1'b0;
      restore_cfg_ff  <= 1'b0;
      sram_wr_deny_ff <= 1'b0;
      sram_ex_deny_ff <= 1'b0;
      flash_wait_ff   <= 1'b1;
    end else begin
      acc_rdata_ff    <= nxt_rdata;
      force_fast_ff   <= ff_fast;
      restore_cfg_ff  <= ff_rst;
      sram_wr_deny_ff <= g_wr;
      sram_ex_deny_ff <= g_ex;
      flash_wait_ff   <= nxt_flash_wait;
    end
  end

  // ------------------------------------------------------------
  // retained shutdown state
  // ------------------------------------------------------------
  // these survive the brownout reset; only the power-on reset clears them
  assign shdn_enter = sleep_req && pmode_ff == `SXC_PMODE_SHDN && !core_reg_off_ff;

  always_comb begin
    nxt_core_off       = core_reg_off_ff;
    nxt_brownout_reset = 1'b0;
    if (shdn_enter) begin
      nxt_core_off = 1'b1;
    end else if (core_reg_off_ff && wake_event) begin
      nxt_core_off       = 1'b0;
      nxt_brownout_reset = 1'b1;
    end
    // entry wins over a release in the same cycle
    nxt_hold = shdn_enter ? 1'b1 : (wr_rel ? 1'b0 : io_hold_ff);
    nxt_held = shdn_enter ? io_cfg_live : io_cfg_held_ff;
    nxt_store = store_ff;
    if (wr_sto) begin
      nxt_store = acc_wdata;
    end
    // a new exit outranks a read-clear in the same cycle
    nxt_cause = nxt_brownout_reset ? 1'b1 : (rd_cause ? 1'b0 : cause_ff);
  end

  always_ff @(posedge mclk or negedge ret_reset_n) begin
    if (!ret_reset_n) begin
      core_reg_off_ff   <= 1'b0;
      brownout_reset_ff <= 1'b0;
      io_hold_ff        <= 1'b0;
      io_cfg_held_ff    <= '0;
      swd_lock_ff       <= 1'b0;
      store_ff          <= 32'h0000_0000;
      cause_ff          <= 1'b0;
    end else begin
      core_reg_off_ff   <= nxt_core_off;
      brownout_reset_ff <= nxt_brownout_reset;
      io_hold_ff        <= nxt_hold;
      io_cfg_held_ff    <= nxt_held;
      swd_lock_ff       <= nxt_hold;
      store_ff          <= nxt_store;
      cause_ff          <= nxt_cause;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_shdn_cycle;
    shdn_enter ##1 core_reg_off_ff;
  endsequence
  property p_lock_blocks;
    @(posedge mclk) disable iff (!reset_n)
      (acc_wr && acc_sel == `SXC_SEL_BOUNDARY && lock_ff) |=> $stable(bnd_ff);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked boundary changed");
  property p_exempt;
    @(posedge mclk) disable iff (!ret_reset_n)
      (wr_sto && lock_ff) |=> store_ff == $past(acc_wdata);
  endproperty
  a_exempt: assert property (p_exempt) else $error("retained store write lost under lock");
  property p_key;
    @(posedge mclk) disable iff (!reset_n)
      (acc_wr && acc_sel == `SXC_SEL_OSCCFG && !key_ok(acc_wdata)) |=> $stable({block_ff, fast_en_ff});
  endproperty
  a_key: assert property (p_key) else $error("unkeyed write took effect");
  property p_shdn;
    @(posedge mclk) disable iff (!ret_reset_n)
      s_shdn_cycle |-> io_hold_ff && swd_lock_ff && io_cfg_held_ff == $past(io_cfg_live);
  endproperty
  a_shdn: assert property (p_shdn) else $error("pins not latched at shutdown");
  property p_release;
    @(posedge mclk) disable iff (!ret_reset_n)
      (io_hold_ff && !shdn_enter && !wr_rel) |=> io_hold_ff;
  endproperty
  a_release: assert property (p_release) else $error("pins released without key");
  property p_cause_clr;
    @(posedge mclk) disable iff (!ret_reset_n)
      (rd_cause && !nxt_brownout_reset) |=> !cause_ff;
  endproperty
  a_cause_clr: assert property (p_cause_clr) else $error("reset cause not cleared by read");
  property p_wait;
    @(posedge mclk) disable iff (!reset_n)
      (mclk_src == sxc_pkg::SXC_SRC_SLOW) |=> flash_wait_ff == `SXC_WS_SLOW;
  endproperty
  a_wait: assert property (p_wait) else $error("wrong wait state on slow clock");
  property p_sram;
    @(posedge mclk) disable iff (!reset_n)
      (sram_write && sram_addr >= bnd_ff) |=> sram_wr_deny_ff;
  endproperty
  a_sram: assert property (p_sram) else $error("write above boundary allowed");
endmodule
